// ---- logic/mic_irq_ctrl.sv ----
// interrupt control unit: flags, enables, vectoring and sleep wake-up
// Contract
// RULE1 - exactly four sources: pin edge, timer overflow, port change, converter done
// RULE2 - flags latch on their event regardless of individual or global enable
// RULE3 - control bit 7 is the global enable; clear blocks all interrupts
// RULE4 - global enable set plus flag and enable set vectors the core
// RULE5 - every reset clears the global enable
// RULE6 - return-from-interrupt exits the routine and sets global enable again
// RULE7 - accepting an interrupt clears global enable, pushes return, loads 0004h
// RULE8 - service routine clears serviced flags before re-enabling interrupts
// RULE9 - pin and port events vector after three or four instruction cycles
// RULE10 - pin edge select: rising when option bit 6 set, falling otherwise
// RULE11 - valid pin edge sets control bit 1; bit 4 enables it
// RULE12 - enabled pin interrupt wakes from sleep; global enable decides vectoring
// RULE13 - timer rollover sets control bit 2; bit 5 enables it
// RULE14 - upper port nibble change sets control bit 0; own enable gates it
// RULE15 - peripheral flags and enables in own registers; control bit 6 gates them
// RULE16 - pin flag may set during Q4 to Q1; logic samples on Q1
// RULE17 - wake with global enable set loads vector; otherwise resume in line
// RULE18 - software disabling interrupts repeats clear and re-test of global enable
// RULE19 - port change coinciding with a port read is never lost
// RULE20 - software may clear flags; request is OR of pairs gated by global enable
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module mic_irq_ctrl
  import mic_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              ext_irq_pin,
  input  wire logic [3:0]        port_b_pins,
  input  wire logic              port_read,
  input  wire logic              timer_overflow,
  input  wire logic              adc_done,
  input  wire logic              return_from_irq_instr,
  input  wire logic              sleep_instr,
  output logic                   irq_req,
  output logic                   vector_take,
  output logic                   push_return,
  output logic      [PC_W-1:0]   vector_addr,
  output logic                   wake,
  output logic                   asleep,
  output mic_phase_t             phase
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] opt_q, opt_d;
  logic [7:0] pfa_q, pfa_d;
  logic [7:0] pea_q, pea_d;
  logic [3:0] latch_q, latch_d;
  logic       ext_prev_q;
  logic [1:0] init_q;
  logic [1:0] lat_q, lat_d;
  logic       asleep_q, asleep_d;
  logic       wake_q;
  logic [7:0] rdata_q;
  mic_phase_t phase_q, phase_d;
  logic       ext_s;
  logic [3:0] port_s;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  mic_sync #(.W(1)) u_sync_ext (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (ext_irq_pin),
    .sync_out (ext_s)
  );

  mic_sync #(.W(4)) u_sync_port (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (port_b_pins),
    .sync_out (port_s)
  );

  // ---------------------------------------------------------------
  // decode and event detection
  // ---------------------------------------------------------------
  wire wr_ctrl  = reg_wr && (reg_addr == OFS_IRQ_CONTROL);
  wire wr_opt   = reg_wr && (reg_addr == OFS_OPTION);
  wire wr_pfa   = reg_wr && (reg_addr == OFS_PFLAG_A);
  wire wr_pea   = reg_wr && (reg_addr == OFS_PEN_A);
  wire init_done = (init_q == INIT_CYCLES);
  wire q1       = (phase_q == MIC_Q1);

  // edge select picks rising or falling pin edges
  wire edge_sel  = opt_q[BIT_EDGE_SEL];
  wire ext_rise  = ext_s && !ext_prev_q;
  wire ext_fall  = !ext_s && ext_prev_q;
  wire ext_event = init_done && (edge_sel ? ext_rise : ext_fall); // RULE10
  // mismatch against last-read value; a read in the same cycle still sets
  wire port_event = init_done && (port_s != latch_q); // RULE14 RULE19
  wire adc_event  = adc_done;
  wire tmr_event  = timer_overflow; // RULE13

  // ---------------------------------------------------------------
  // request combination
  // ---------------------------------------------------------------
  wire global_irq_enable      = ctrl_q[BIT_GIE]; // RULE3
  wire ext_pair = ctrl_q[BIT_EXT_PIN_FLAG] && ctrl_q[BIT_EXT_PIN_ENABLE]; // RULE11
  wire tmr_pair = ctrl_q[BIT_TIMER_OVERFLOW_FLAG] && ctrl_q[BIT_TIMER_OVERFLOW_ENABLE]; // RULE13
  wire rb_pair  = ctrl_q[BIT_PORT_CHANGE_FLAG] && ctrl_q[BIT_PORT_CHANGE_ENABLE]; // RULE14
  wire per_any  = |(pfa_q & pea_q);
  wire per_pair = per_any && ctrl_q[BIT_PEIE]; // RULE15
  wire any_pair = ext_pair || tmr_pair || rb_pair || per_pair; // RULE1 RULE20
  wire pending  = global_irq_enable && any_pair; // RULE4 RULE20
  // wake ignores global enable; peripherals need their group enable too
  wire wake_cond = asleep_q && any_pair; // RULE12
  // vector on the last q1 sample of an uninterrupted pending request
  wire take     = q1 && pending && !asleep_q && (lat_q == LAT_LAST_SAMPLE); // RULE9 RULE16

  // ---------------------------------------------------------------
  // next state of control register: events win over software clears
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_d = wr_ctrl ? reg_wdata : ctrl_q; // RULE20
    if (ext_event)
      ctrl_d[BIT_EXT_PIN_FLAG] = 1'b1; // RULE2 RULE11
    if (tmr_event)
      ctrl_d[BIT_TIMER_OVERFLOW_FLAG] = 1'b1; // RULE2 RULE13
    if (port_event)
      ctrl_d[BIT_PORT_CHANGE_FLAG] = 1'b1; // RULE2 RULE14
    if (return_from_irq_instr)
      ctrl_d[BIT_GIE] = 1'b1; // RULE6
    if (take)
      ctrl_d[BIT_GIE] = 1'b0; // RULE7
  end

  // peripheral registers; converter completion lives in register a
  always_comb
  begin
    pfa_d = wr_pfa ? (reg_wdata & (8'h01 << BIT_ADC)) : pfa_q;
    if (adc_event)
      pfa_d[BIT_ADC] = 1'b1; // RULE2 RULE15
    pea_d = wr_pea ? (reg_wdata & (8'h01 << BIT_ADC)) : pea_q;
    opt_d = wr_opt ? reg_wdata : opt_q;
  end

  // latency counter counts consecutive q1 samples of a pending request
  always_comb
  begin
    lat_d = lat_q;
    if (q1)
    begin
      if (!pending || asleep_q || take)
        lat_d = 2'h0;
      else
        lat_d = lat_q + 2'h1; // RULE9 RULE16
    end
  end

  // sleep state: entered by the sleep instruction, left on an enabled event
  always_comb
  begin
    asleep_d = asleep_q;
    if (sleep_instr && !any_pair)
      asleep_d = 1'b1;
    if (wake_cond)
      asleep_d = 1'b0; // RULE12 RULE17
  end

  // four-phase sequencer
  always_comb
  begin
    unique case (phase_q)
      MIC_Q1: phase_d = MIC_Q2;
      MIC_Q2: phase_d = MIC_Q3;
      MIC_Q3: phase_d = MIC_Q4;
      MIC_Q4: phase_d = MIC_Q1;
    endcase
  end

  // port latch follows the pins on a read and while settling after reset
  assign latch_d = (port_read || !init_done) ? port_s : latch_q;

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  wire [7:0] status_val = (8'(pending) << BIT_ST_REQ) | (8'(asleep_q) << BIT_ST_ASLEEP);
  wire [7:0] rd_mux =
    (reg_addr == OFS_IRQ_CONTROL) ? ctrl_q :
    (reg_addr == OFS_OPTION)      ? opt_q  :
    (reg_addr == OFS_PFLAG_A)     ? pfa_q  :
    (reg_addr == OFS_PEN_A)       ? pea_q  :
    (reg_addr == OFS_STATUS)      ? status_val : READ_ZERO;

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // control and configuration; reset clears the global enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= RST_IRQ_CONTROL; // RULE5
      opt_q  <= RST_OPTION;
      pfa_q  <= RST_PERIPH;
      pea_q  <= RST_PERIPH;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      opt_q  <= opt_d;
      pfa_q  <= pfa_d;
      pea_q  <= pea_d;
    end
  end

  // sequencing, edge history and sleep
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q    <= MIC_Q1;
      lat_q      <= 2'h0;
      asleep_q   <= 1'b0;
      wake_q     <= 1'b0;
      ext_prev_q <= 1'b0;
      latch_q    <= 4'h0;
      init_q     <= 2'h0;
    end
    else
    begin
      phase_q    <= phase_d;
      lat_q      <= lat_d;
      asleep_q   <= asleep_d;
      wake_q     <= wake_cond;
      ext_prev_q <= ext_s;
      latch_q    <= latch_d;
      init_q     <= init_done ? init_q : init_q + 2'h1;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= READ_ZERO;
    else
      rdata_q <= reg_rd ? rd_mux : READ_ZERO;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata   = rdata_q;
  assign irq_req     = pending;
  assign vector_take = take; // RULE7
  assign push_return = take; // RULE7
  assign vector_addr = IRQ_VECTOR; // RULE7 RULE17
  assign wake        = wake_q;
  assign asleep      = asleep_q;
  assign phase       = phase_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_VEC_CLEARS_GIE: assert property ( // RULE7
    take && !return_from_irq_instr |=> !ctrl_q[BIT_GIE])
    else $error("global enable not cleared after vector");
  AST_RETURN_SETS_GIE: assert property ( // RULE6
    return_from_irq_instr && !take |=> ctrl_q[BIT_GIE])
    else $error("return did not set global enable");
  AST_TMR_FLAG_SETS: assert property ( // RULE2
    tmr_event |=> ctrl_q[BIT_TIMER_OVERFLOW_FLAG])
    else $error("timer flag lost");
  AST_EXT_EDGE_FLAG: assert property ( // RULE10
    init_done && ext_s && !ext_prev_q && opt_q[BIT_EDGE_SEL] |=> ctrl_q[BIT_EXT_PIN_FLAG])
    else $error("rising pin edge did not set flag");
  AST_PORT_CHANGE_FLAG: assert property ( // RULE19
    init_done && port_read && (port_s != latch_q) |=> ctrl_q[BIT_PORT_CHANGE_FLAG])
    else $error("port change lost during read");
  AST_ADC_FLAG: assert property ( // RULE15
    adc_done |=> pfa_q[BIT_ADC])
    else $error("converter flag lost");
  AST_NO_GIE_NO_VECTOR: assert property ( // RULE3
    !ctrl_q[BIT_GIE] |-> ##1 !vector_take[*2])
    else $error("vector taken with global enable clear");
  AST_LATENCY_MIN: assert property ( // RULE9
    vector_take |-> $past(irq_req, 8) && $past(phase_q == MIC_Q1, 8))
    else $error("vector taken too early");
  AST_LATENCY_MAX: assert property ( // RULE9
    $rose(ext_pair) && global_irq_enable && !asleep_q |->
      ##[1:17] (vector_take || !irq_req || asleep_q))
    else $error("vector latency too long");
  AST_WAKE_ON_PIN: assert property ( // RULE12
    asleep_q && ext_pair |=> !asleep_q ##0 wake_q)
    else $error("enabled pin event did not wake");
  AST_NO_VECTOR_ASLEEP: assert property ( // RULE17
    asleep_q |-> !vector_take)
    else $error("vector taken while asleep");
  AST_SW_CLEAR: assert property ( // RULE20
    wr_ctrl && !reg_wdata[BIT_TIMER_OVERFLOW_FLAG] && !tmr_event |=> !ctrl_q[BIT_TIMER_OVERFLOW_FLAG])
    else $error("software clear of timer flag ignored");

  COV_VECTOR: cover property (vector_take);
  COV_WAKE_THEN_VECTOR: cover property (wake_q ##[1:20] vector_take);
  COV_RETURN_AFTER_VECTOR: cover property (vector_take ##[1:40] return_from_irq_instr);
endmodule

// ---- logic/mic_pkg.sv ----
// constants, register map and phase type of the interrupt control unit
package mic_pkg;
  // register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_IRQ_CONTROL = 3'h0;
  localparam logic [2:0] OFS_OPTION      = 3'h1;
  localparam logic [2:0] OFS_PFLAG_A     = 3'h2;
  localparam logic [2:0] OFS_PEN_A       = 3'h3;
  localparam logic [2:0] OFS_PFLAG_B     = 3'h4;
  localparam logic [2:0] OFS_PEN_B       = 3'h5;
  localparam logic [2:0] OFS_STATUS      = 3'h6;

  // irq_control_reg bit positions
  localparam int unsigned BIT_GIE  = 7;
  localparam int unsigned BIT_PEIE = 6;
  localparam int unsigned BIT_TIMER_OVERFLOW_ENABLE = 5;
  localparam int unsigned BIT_EXT_PIN_ENABLE = 4;
  localparam int unsigned BIT_PORT_CHANGE_ENABLE = 3;
  localparam int unsigned BIT_TIMER_OVERFLOW_FLAG = 2;
  localparam int unsigned BIT_EXT_PIN_FLAG = 1;
  localparam int unsigned BIT_PORT_CHANGE_FLAG = 0;

  // option register: edge select bit
  localparam int unsigned BIT_EDGE_SEL = 6;
  // converter completion bit in peripheral flag/enable register a
  localparam int unsigned BIT_ADC = 0;
  // status register bits
  localparam int unsigned BIT_ST_ASLEEP = 0;
  localparam int unsigned BIT_ST_REQ    = 1;

  // reset values
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPTION      = 8'hff;
  localparam logic [7:0] RST_PERIPH      = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // program counter vector and width
  localparam int unsigned PC_W = 13;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // timing: clock and instruction cycle
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned CLK_PER_TCY  = 4;
  // q1 samples of a pending request before the vector is taken
  localparam logic [1:0] LAT_LAST_SAMPLE = 2'h3;
  // cycles after reset release before the port latch is trusted
  localparam logic [1:0] INIT_CYCLES     = 2'h3;

  // four-phase instruction clock
  typedef enum logic [1:0] {
    MIC_Q1 = 2'b00,
    MIC_Q2 = 2'b01,
    MIC_Q3 = 2'b10,
    MIC_Q4 = 2'b11
  } mic_phase_t;
endpackage

// ---- logic/mic_sync.sv ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module mic_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- tb/mic_core_model.sv ----
// core sequencer model: program counter load and return stack depth
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            vector_take,
  input  wire logic            push_return,
  input  wire logic [PC_W-1:0] vector_addr,
  input  wire logic            return_from_irq_instr,
  output logic      [PC_W-1:0] pc_q,
  output logic      [3:0]      depth_q
);
  // branch and push on accept, pop on return, else run in line
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q    <= '0;
      depth_q <= '0;
    end
    else if (vector_take)
    begin
      pc_q    <= vector_addr;
      depth_q <= depth_q + {3'h0, push_return};
    end
    else
    begin
      pc_q <= pc_q + 13'h0001; // in-line execution
      if (return_from_irq_instr)
        depth_q <= depth_q - 4'h1;
    end
  end
endmodule

// ---- tb/mcu_interrupt_control_tb.sv ----
// self-checking bench of the interrupt control unit beside a core model
`timescale 1ns/1ps
module mcu_interrupt_control_tb;
  import mic_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [2:0]        addr;
  logic [7:0]        wd;
  logic              wr;
  logic              rd;
  logic [7:0]        reg_rdata;
  logic              pin;
  logic [3:0]        pb;
  logic [4:0]        ev;
  logic              irq_req;
  logic              vt;
  logic              pr;
  logic [PC_W-1:0]   va;
  logic              wake;
  logic              asleep;
  mic_phase_t        phase;
  logic [PC_W-1:0]   pc;
  logic [3:0]        depth;
  int                mismatches;
  int                checked;
  int                cyc;
  int                vcount;
  int                n;

  mic_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(reg_rdata), .ext_irq_pin(pin),
    .port_b_pins(pb), .port_read(ev[4]), .timer_overflow(ev[0]), .adc_done(ev[1]),
    .return_from_irq_instr(ev[2]), .sleep_instr(ev[3]), .irq_req(irq_req),
    .vector_take(vt), .push_return(pr), .vector_addr(va), .wake(wake),
    .asleep(asleep), .phase(phase));
  mic_core_model core (.clk(clk), .rst_n(rst_n), .vector_take(vt), .push_return(pr),
    .vector_addr(va), .return_from_irq_instr(ev[2]), .pc_q(pc), .depth_q(depth));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask
  task rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
  endtask
  // counts edges until the vector is taken, bounded
  task wait_vec(output int k);
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end while (vt !== 1'b1 && k < 40);
  endtask

  // clock and cycle limit
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    vcount = vcount + ((vt === 1'b1) ? 1 : 0);
    if (cyc == 3000)
    begin
      mismatches++;
      finish_test;
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; addr = '0; wd = '0; wr = 1'b0; rd = 1'b0;
    pin = 1'b0; pb = '0; ev = '0; mismatches = 0; checked = 0; cyc = 0; vcount = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, RST_IRQ_CONTROL);
    rd_chk(OFS_OPTION, RST_OPTION);
    rd_chk(3'h7, READ_ZERO);
    wr_reg(OFS_STATUS, 8'hff);
    rd_chk(OFS_STATUS, 8'h00);
    // flags latch with every enable clear
    pulse(5'h03);
    rd_chk(OFS_IRQ_CONTROL, 8'h04);
    rd_chk(OFS_PFLAG_A, 8'h01);
    chk("irq_req", 16'h0, irq_req);
    // peripheral request gated by its enable, then serviced
    wr_reg(OFS_IRQ_CONTROL, 8'hc0);
    #1;
    chk("irq_req", 16'h0, irq_req);
    wr_reg(OFS_PEN_A, 8'h01);
    wait_vec(n);
    chk("vector_addr", 16'h0004, va);
    chk("phase", {14'h0, MIC_Q1}, {14'h0, phase});
    chk("vec_fast", 16'h1, n <= 16);
    @(posedge clk);
    #1;
    chk("pc", 16'h0004, pc);
    chk("depth", 16'h1, depth);
    rd_chk(OFS_IRQ_CONTROL, 8'h40);
    wr_reg(OFS_PFLAG_A, 8'h00);
    pulse(5'h04);
    rd_chk(OFS_IRQ_CONTROL, 8'hc0);
    chk("depth", 16'h0, depth);
    chk("irq_req", 16'h0, irq_req);
    // pin rising edge latency to the vector
    wr_reg(OFS_IRQ_CONTROL, 8'h90);
    @(posedge clk);
    pin <= 1'b1;
    wait_vec(n);
    chk("latency", 16'h1, n >= 12 && n <= 20);
    rd_chk(OFS_IRQ_CONTROL, 8'h12);
    wr_reg(OFS_IRQ_CONTROL, 8'h10);
    rd_chk(OFS_IRQ_CONTROL, 8'h10);
    // falling edge selected: fall sets, rise does not
    wr_reg(OFS_OPTION, 8'hbf);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, 8'h12);
    wr_reg(OFS_IRQ_CONTROL, 8'h10);
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, 8'h10);
    // port change coinciding with a port read
    pulse(5'h10);
    wr_reg(OFS_IRQ_CONTROL, 8'h00);
    @(posedge clk);
    pb <= 4'h5;
    repeat (2) @(posedge clk);
    ev <= 5'h10; // read lands while synced pins differ from the latch
    @(posedge clk);
    ev <= '0;
    repeat (8) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, 8'h01);
    // sleep, wake on enabled pin edge, no vector with global enable clear
    wr_reg(OFS_OPTION, 8'hff);
    wr_reg(OFS_IRQ_CONTROL, 8'h10);
    pulse(5'h08);
    #1;
    chk("asleep", 16'h1, asleep);
    vcount = 0;
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (wake !== 1'b1 && n < 20);
    chk("wake", 16'h1, wake);
    chk("asleep", 16'h0, asleep);
    repeat (20) @(posedge clk);
    chk("vector_count", 16'h0, vcount[15:0]);
    // sleep with global enable set: wake, then vector
    wr_reg(OFS_IRQ_CONTROL, 8'h90);
    pulse(5'h08);
    #1;
    chk("asleep", 16'h1, asleep);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    wait_vec(n);
    chk("vector_take", 16'h1, vt);
    chk("wake_vec_fast", 16'h1, n <= 20);
    @(posedge clk);
    #1;
    chk("pc", 16'h0004, pc);
    // mid-run reset clears the global enable
    wr_reg(OFS_IRQ_CONTROL, 8'h80);
    rd_chk(OFS_IRQ_CONTROL, 8'h80);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(OFS_IRQ_CONTROL, RST_IRQ_CONTROL);
    finish_test;
  end
endmodule
